// ==== ers_pkg.sv ====
// Package for the receive timestamp, link status and reset block.
// Assumes a single 100 MHz pclk domain and an APB register slave.
package ers_pkg;
	localparam int        TOD_V2_W       = 96;
	localparam int        TOD_SHORT_W    = 64;
	localparam int        LANES          = 4;
	localparam logic [11:0] ADDR_CTRL    = 12'h000;
	localparam logic [11:0] ADDR_STATUS  = 12'h004;
	localparam logic [11:0] ADDR_RSTCNT  = 12'h008;
	localparam logic [11:0] ADDR_SCRATCH = 12'h00C;
	localparam int        CTRL_LFG_BIT   = 0;
	localparam int        CTRL_UNI_BIT   = 1;
	localparam logic [1:0] CTRL_RESET    = 2'h0;
	localparam logic [31:0] SCRATCH_RESET = 32'h0000_0000;
	localparam int        RST_HOLD_CYC   = 10;
	localparam logic [3:0] RST_STAGES    = 4'h2;
	localparam int        CLK_PERIOD_NS  = 10;
	typedef enum logic [1:0] {
		ERS_FMT_V2,
		ERS_FMT_SHORT,
		ERS_FMT_BOTH
	} ers_fmt_t;
endpackage

// ==== ers_top.sv ====
// Receive arrival timestamps, link status levels and hard reset handling.
// Assumes status inputs are asynchronous pins; rx_sop and time come on pclk.
// Overview of operation
// - Present a 96-bit V2 arrival time for each received frame.
// - Present a 64-bit short arrival time for each received frame.
// - Timestamps appear for every frame, timing packet or not.
// - Timestamp value is valid in the cycle after start-of-packet.
// - Each timestamp valid strobe follows start-of-packet by exactly one cycle.
// - Each timestamp format exists only when the format setting selects it.
// - Status outputs are asynchronous levels to the consumer.
// - Lanes-stable asserts only when every transmit lane is stable.
// - Block lock asserts only when every receive lane has block lock.
// - Alignment ready asserts only when all receive lanes are aligned.
// - Local fault output follows receive MAC local fault detection.
// - Remote fault output follows receive MAC remote fault detection.
// - Fault and unidirectional outputs exist only with link fault generation.
// - Both unidirectional indicators held high when built with that feature and CTRL bit 1 is clear.
// - Three async active-low resets, each synchronized before use.
// - Reset exit signalled by alignment ready and lanes stable both high.
// - Transmit reset clears transmit side and drops lanes-stable.
// - Receive reset clears receive side and drops alignment ready.
// - Global reset clears both sides and the registers and drops both readiness outputs.
// - Global reset returns every register to its initial value.
// - Transmit and receive resets leave CTRL and SCRATCH untouched and increment RSTCNT.
`timescale 1ns/1ps
module ers_top #(
	parameter ers_pkg::ers_fmt_t TOD_FORMAT  = ers_pkg::ERS_FMT_BOTH,
	parameter bit                LINK_FAULT_GEN = 1'b1,
	parameter bit                UNIDIR_SUPPORT = 1'b1
) (
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	input  wire logic                              tx_rst_n,
	input  wire logic                              rx_rst_n,
	input  wire logic                              csr_rst_n,
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [11:0]                       paddr,
	input  wire logic [31:0]                       pwdata,
	output logic      [31:0]                       prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	input  wire logic                              rx_sop,
	input  wire logic [ers_pkg::TOD_V2_W-1:0]      tod_v2,
	input  wire logic [ers_pkg::TOD_SHORT_W-1:0]   tod_short,
	input  wire logic [ers_pkg::LANES-1:0]         tx_lane_ok,
	input  wire logic [ers_pkg::LANES-1:0]         rx_lane_lock,
	input  wire logic [ers_pkg::LANES-1:0]         rx_lane_aligned,
	input  wire logic                              rx_local_fault,
	input  wire logic                              rx_remote_fault,
	output logic [ers_pkg::TOD_V2_W-1:0]           rx_arrival_time_v2,
	output logic                                   rx_arrival_time_v2_ok,
	output logic [ers_pkg::TOD_SHORT_W-1:0]        rx_arrival_time_short,
	output logic                                   rx_arrival_time_short_ok,
	output logic                                   tx_lanes_stable,
	output logic                                   rx_block_lock,
	output logic                                   rx_pcs_ready,
	output logic                                   local_fault_status,
	output logic                                   remote_fault_status,
	output logic                                   unidirectional_en,
	output logic                                   link_fault_gen_en
);
	import ers_pkg::*;

	localparam bit HAS_V2    = (TOD_FORMAT != ERS_FMT_SHORT);
	localparam bit HAS_SHORT = (TOD_FORMAT != ERS_FMT_V2);

	// Reset synchronisers: assert async, release through two flops
	logic [1:0] tx_rs_q;
	logic [1:0] rx_rs_q;
	logic [1:0] csr_rs_q;
	logic       tx_rst_ok;
	logic       rx_rst_ok;
	logic       csr_rst_ok;

	always_ff @(posedge pclk or negedge tx_rst_n) begin
		if (!tx_rst_n) begin
			tx_rs_q <= 2'h0;
		end else begin
			tx_rs_q <= {tx_rs_q[0], 1'b1};
		end
	end

	always_ff @(posedge pclk or negedge rx_rst_n) begin
		if (!rx_rst_n) begin
			rx_rs_q <= 2'h0;
		end else begin
			rx_rs_q <= {rx_rs_q[0], 1'b1};
		end
	end

	always_ff @(posedge pclk or negedge csr_rst_n) begin
		if (!csr_rst_n) begin
			csr_rs_q <= 2'h0;
		end else begin
			csr_rs_q <= {csr_rs_q[0], 1'b1};
		end
	end

	// Global reset overrides the side resets
	assign csr_rst_ok = csr_rs_q[1] & presetn;
	assign tx_rst_ok  = tx_rs_q[1] & csr_rst_ok;
	assign rx_rst_ok  = rx_rs_q[1] & csr_rst_ok;

	// Async status pins: two flops before use
	logic [LANES-1:0] txl_s1_q;
	logic [LANES-1:0] txl_s2_q;
	logic [LANES-1:0] rxk_s1_q;
	logic [LANES-1:0] rxk_s2_q;
	logic [LANES-1:0] rxa_s1_q;
	logic [LANES-1:0] rxa_s2_q;
	logic [1:0]       flt_s1_q;
	logic [1:0]       flt_s2_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txl_s1_q <= '0;
			txl_s2_q <= '0;
			rxk_s1_q <= '0;
			rxk_s2_q <= '0;
			rxa_s1_q <= '0;
			rxa_s2_q <= '0;
			flt_s1_q <= 2'h0;
			flt_s2_q <= 2'h0;
		end else begin
			txl_s1_q <= tx_lane_ok;
			txl_s2_q <= txl_s1_q;
			rxk_s1_q <= rx_lane_lock;
			rxk_s2_q <= rxk_s1_q;
			rxa_s1_q <= rx_lane_aligned;
			rxa_s2_q <= rxa_s1_q;
			flt_s1_q <= {rx_remote_fault, rx_local_fault};
			flt_s2_q <= flt_s1_q;
		end
	end

	// Register bank: held only by the global reset
	logic [1:0]  ctrl_q;
	logic [31:0] scratch_q;
	logic [7:0]  side_rst_cnt_q;
	logic        tx_ok_d1_q;
	logic        rx_ok_d1_q;
	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;

	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
		(paddr == ADDR_RSTCNT) || (paddr == ADDR_SCRATCH);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q    <= CTRL_RESET;
			scratch_q <= SCRATCH_RESET;
		end else if (!csr_rst_ok) begin
			ctrl_q    <= CTRL_RESET;
			scratch_q <= SCRATCH_RESET;
		end else if (wr_en) begin
			// Side resets do not touch these
			if (paddr == ADDR_CTRL) begin
				ctrl_q <= pwdata[1:0];
			end else if (paddr == ADDR_SCRATCH) begin
				scratch_q <= pwdata;
			end
		end
	end

	// Counts side-reset entries, tx and rx together in one count; the global reset clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_ok_d1_q     <= 1'b0;
			rx_ok_d1_q     <= 1'b0;
			side_rst_cnt_q <= 8'h00;
		end else begin
			tx_ok_d1_q <= tx_rst_ok;
			rx_ok_d1_q <= rx_rst_ok;
			if (!csr_rst_ok) begin
				side_rst_cnt_q <= 8'h00;
			end else if ((tx_ok_d1_q & ~tx_rst_ok) | (rx_ok_d1_q & ~rx_rst_ok)) begin
				side_rst_cnt_q <= side_rst_cnt_q + 8'h01;
			end
		end
	end

	// APB answers in the access cycle; no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok;
			if (psel & ~penable & ~pwrite) begin
				if (paddr == ADDR_CTRL) begin
					prdata <= {30'h0, ctrl_q};
				end else if (paddr == ADDR_STATUS) begin
					prdata <= {25'h0, link_fault_gen_en, unidirectional_en,
						remote_fault_status, local_fault_status, rx_pcs_ready,
						rx_block_lock, tx_lanes_stable};
				end else if (paddr == ADDR_RSTCNT) begin
					prdata <= {24'h0, side_rst_cnt_q};
				end else if (paddr == ADDR_SCRATCH) begin
					prdata <= scratch_q;
				end else begin
					prdata <= 32'h0000_0000;
				end
			end else if (rd_en) begin
				prdata <= prdata;
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// Timestamps: registered on sop together with the strobe so value and strobe align.
	// Output registers give one cycle of latency to sop and time alike.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_arrival_time_v2    <= '0;
			rx_arrival_time_v2_ok <= 1'b0;
		end else if (!rx_rst_ok || !HAS_V2) begin
			rx_arrival_time_v2    <= '0;
			rx_arrival_time_v2_ok <= 1'b0;
		end else begin
			rx_arrival_time_v2_ok <= rx_sop;
			if (rx_sop) begin
				rx_arrival_time_v2 <= tod_v2;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_arrival_time_short    <= '0;
			rx_arrival_time_short_ok <= 1'b0;
		end else if (!rx_rst_ok || !HAS_SHORT) begin
			rx_arrival_time_short    <= '0;
			rx_arrival_time_short_ok <= 1'b0;
		end else begin
			rx_arrival_time_short_ok <= rx_sop;
			if (rx_sop) begin
				rx_arrival_time_short <= tod_short;
			end
		end
	end

	// Status levels; consumers resynchronise them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_lanes_stable <= 1'b0;
		end else begin
			tx_lanes_stable <= tx_rst_ok & (&txl_s2_q);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_block_lock <= 1'b0;
			rx_pcs_ready  <= 1'b0;
		end else begin
			rx_block_lock <= rx_rst_ok & (&rxk_s2_q);
			rx_pcs_ready  <= rx_rst_ok & (&rxa_s2_q) & (&rxk_s2_q);
		end
	end

	// Fault outputs gated by the build option; software may also mask them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			local_fault_status  <= 1'b0;
			remote_fault_status <= 1'b0;
			unidirectional_en   <= 1'b0;
			link_fault_gen_en   <= 1'b0;
		end else begin
			local_fault_status  <= LINK_FAULT_GEN & rx_rst_ok & flt_s2_q[0] &
				~ctrl_q[CTRL_LFG_BIT];
			remote_fault_status <= LINK_FAULT_GEN & rx_rst_ok & flt_s2_q[1] &
				~ctrl_q[CTRL_LFG_BIT];
			unidirectional_en   <= LINK_FAULT_GEN & UNIDIR_SUPPORT &
				~ctrl_q[CTRL_UNI_BIT];
			link_fault_gen_en   <= LINK_FAULT_GEN & UNIDIR_SUPPORT &
				~ctrl_q[CTRL_UNI_BIT];
		end
	end

endmodule // ers_top

// ==== ers_monitor.sv ====
// Checker on ers_top ports: timestamp strobes, lane status, reset drops.
// Assumes every signal is sampled on pclk; bound from the testbench.
`timescale 1ns/1ps
module ers_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        tx_rst_n,
	input wire logic        rx_rst_n,
	input wire logic        csr_rst_n,
	input wire logic        rx_sop,
	input wire logic [95:0] tod_v2,
	input wire logic [3:0]  tx_lane_ok,
	input wire logic [3:0]  rx_lane_lock,
	input wire logic [3:0]  rx_lane_aligned,
	input wire logic [95:0] rx_arrival_time_v2,
	input wire logic        rx_arrival_time_v2_ok,
	input wire logic        rx_arrival_time_short_ok,
	input wire logic        tx_lanes_stable,
	input wire logic        rx_block_lock,
	input wire logic        rx_pcs_ready
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	v2_strobe_a: assert property (
		rx_sop && rx_rst_n && csr_rst_n |=> rx_arrival_time_v2_ok) else $error("v2 strobe lost");
	short_strobe_a: assert property (
		rx_sop && rx_rst_n && csr_rst_n |=> rx_arrival_time_short_ok) else $error("short strobe lost");
	no_stray_a: assert property (
		!rx_sop |=> !rx_arrival_time_v2_ok) else $error("strobe without sop");
	v2_value_a: assert property (
		rx_sop && rx_rst_n |=> rx_arrival_time_v2 == $past(tod_v2)) else $error("v2 time wrong");
	lanes_ok_a: assert property (
		tx_lanes_stable |-> $past(&tx_lane_ok, 3)) else $error("lanes stable early");
	lock_all_a: assert property (
		rx_block_lock |-> $past(&rx_lane_lock, 3)) else $error("block lock early");
	align_all_a: assert property (
		rx_pcs_ready |-> $past(&rx_lane_aligned, 3)) else $error("pcs ready early");
	tx_drop_a: assert property (
		!tx_rst_n |-> ##[0:3] !tx_lanes_stable) else $error("tx reset kept stable");
	rx_drop_a: assert property (
		!rx_rst_n |-> ##[0:3] !rx_pcs_ready) else $error("rx reset kept ready");
	csr_drop_a: assert property (
		!csr_rst_n |-> ##[0:3] !(tx_lanes_stable || rx_pcs_ready)) else $error("global reset ignored");
	cover property (rx_sop ##1 rx_sop);
	cover property (!tx_rst_n);
	cover property (!csr_rst_n);
endmodule // ers_monitor

// ==== ers_partner.sv ====
// RX client and reset controller model: start-of-packet, time of day, hard resets.
// Assumes go and rst_req come from the bench on pclk.
`timescale 1ns/1ps
module ers_partner (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        go,
	input  wire logic [2:0]  rst_req,
	output logic             rx_sop,
	output logic [95:0]      tod_v2,
	output logic [63:0]      tod_short,
	output logic             tx_rst_n,
	output logic             rx_rst_n,
	output logic             csr_rst_n
);
	import ers_pkg::*;
	logic [63:0] time_q;
	logic [4:0]  hold_q;
	logic [2:0]  low_q;
	// Distinct patterns so a swapped format shows
	assign tod_v2 = {32'hA5A5_A5A5, time_q};
	assign tod_short = ~time_q;
	assign {csr_rst_n, rx_rst_n, tx_rst_n} = ~low_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			time_q <= 64'h0;
			rx_sop <= 1'b0;
		end else begin
			time_q <= time_q + 64'h1;
			rx_sop <= go;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_q <= 3'h0;
			hold_q <= 5'h0;
		end else if (hold_q != 5'h0) begin
			hold_q <= hold_q - 5'h1;
			if (hold_q == 5'h1) begin
				low_q <= 3'h0;
			end
		end else if (rst_req != 3'h0) begin
			low_q <= rst_req;
			hold_q <= 5'(RST_HOLD_CYC);
		end
	end
endmodule // ers_partner

// ==== ers_top_tb.sv ====
// Testbench for ers_top: timestamps, status levels, hard resets, APB access.
// Assumes ers_partner stands in for the RX client and reset controller.
`timescale 1ns/1ps
module ers_top_tb;
	import ers_pkg::*;
	logic        pclk, presetn, go, psel, penable, pwrite, pready, pslverr, rx_sop, er;
	logic        tx_rst_n, rx_rst_n, csr_rst_n, rx_local_fault, rx_remote_fault;
	logic        rx_arrival_time_v2_ok, rx_arrival_time_short_ok, tx_lanes_stable;
	logic        rx_block_lock, rx_pcs_ready, local_fault_status, remote_fault_status;
	logic        unidirectional_en, link_fault_gen_en;
	logic [2:0]  rst_req;
	logic [3:0]  tx_lane_ok, rx_lane_lock, rx_lane_aligned;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [63:0] tod_short, rx_arrival_time_short;
	logic [95:0] tod_v2, rx_arrival_time_v2;
	int          n_fail, samples_checked, cyc;
	ers_top u_dut (.pclk, .presetn, .tx_rst_n, .rx_rst_n, .csr_rst_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .rx_sop, .tod_v2, .tod_short, .tx_lane_ok,
		.rx_lane_lock, .rx_lane_aligned, .rx_local_fault, .rx_remote_fault, .rx_arrival_time_v2,
		.rx_arrival_time_v2_ok, .rx_arrival_time_short, .rx_arrival_time_short_ok,
		.tx_lanes_stable, .rx_block_lock, .rx_pcs_ready, .local_fault_status,
		.remote_fault_status, .unidirectional_en, .link_fault_gen_en);
	ers_partner u_far (.pclk, .presetn, .go, .rst_req, .rx_sop, .tod_v2, .tod_short,
		.tx_rst_n, .rx_rst_n, .csr_rst_n);
	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		// Callers may return off the edge; launch the setup cycle on a rising edge
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic t_exit;
		while (!(tx_lanes_stable === 1'b1 && rx_pcs_ready === 1'b1)) @(posedge pclk);
		#1;
		chk(unidirectional_en, 1'b1);
		chk(link_fault_gen_en, 1'b1);
		$display("reset exit done");
	endtask
	task automatic t_ts;
		logic [95:0] ev;
		logic [63:0] es;
		logic eo;
		eo = 1'b0;
		for (int i = 0; i < 8; i++) begin
			@(posedge pclk);
			go <= (i < 3);
			#1;
			chk(rx_arrival_time_v2_ok, eo);
			chk(rx_arrival_time_short_ok, eo);
			if (eo) chk(rx_arrival_time_v2, ev);
			if (eo) chk(rx_arrival_time_short, es);
			eo = rx_sop;
			ev = tod_v2;
			es = tod_short;
		end
		$display("timestamp test done");
	endtask
	task automatic t_status;
		for (int k = 0; k < 2; k++) begin
			@(posedge pclk);
			tx_lane_ok <= k ? 4'hF : 4'hB;
			rx_lane_lock <= k ? 4'hF : 4'h7;
			rx_lane_aligned <= k ? 4'hF : 4'hE;
			rx_local_fault <= !k;
			rx_remote_fault <= !k;
			repeat (5) @(posedge pclk);
			#1;
			chk(tx_lanes_stable, k);
			chk(rx_block_lock, k);
			chk(rx_pcs_ready, k);
			chk(local_fault_status, !k);
			chk(remote_fault_status, !k);
		end
		$display("status test done");
	endtask
	task automatic t_rst(input logic [2:0] r);
		apb(1'b1, ADDR_SCRATCH, 32'h5A5A_0F0F);
		rst_req <= r;
		@(posedge pclk);
		rst_req <= 3'h0;
		repeat (6) @(posedge pclk);
		#1;
		chk(tx_lanes_stable, !(r[0] | r[2]));
		chk(rx_pcs_ready, !(r[1] | r[2]));
		repeat (20) @(posedge pclk);
		apb(1'b0, ADDR_SCRATCH, 32'h0);
		chk(rd, r[2] ? SCRATCH_RESET : 32'h5A5A_0F0F);
		t_exit();
	endtask
	task automatic t_bus;
		apb(1'b0, 12'h0F0, 32'h0);
		chk({er, rd}, {1'b1, 32'h0});
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[6:0], 7'h67);
		$display("bus test done");
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Whole run is under 1000 cycles; hang guard well above it
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 4000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		{presetn, go, psel, penable, pwrite, rx_local_fault, rx_remote_fault} = '0;
		{rst_req, paddr, pwdata} = '0;
		{tx_lane_ok, rx_lane_lock, rx_lane_aligned} = 12'hFFF;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_exit();
		t_ts();
		t_status();
		t_rst(3'h1);
		t_rst(3'h2);
		t_rst(3'h4);
		t_bus();
		end_of_test();
	end
endmodule // ers_top_tb
bind ers_top ers_monitor u_mon (.pclk, .presetn, .tx_rst_n, .rx_rst_n, .csr_rst_n, .rx_sop,
	.tod_v2, .tx_lane_ok, .rx_lane_lock, .rx_lane_aligned, .rx_arrival_time_v2,
	.rx_arrival_time_v2_ok, .rx_arrival_time_short_ok, .tx_lanes_stable, .rx_block_lock,
	.rx_pcs_ready);
